// >>> bench/ext_clk_src.sv
// Behavioural external count clock source for the timer bench
`timescale 1ns/1ns
module ext_clk_src #(
  parameter int HALF = 5  // Clocks per high half and per low half
) (
  input  wire logic sys_clk_in,  // Bench system clock
  output logic      pin_out      // Count pin, rests low between bursts
);
  // Pin rests low, so no stray rising edge appears outside a burst
  initial begin
    pin_out = 1'b0;
  end

  // Send n whole pulses; each level change follows a clock edge
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_in);
      pin_out <= 1'b1;
      repeat (HALF) @(posedge sys_clk_in);
      pin_out <= 1'b0;
      repeat (HALF - 1) @(posedge sys_clk_in);
    end
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; \
  if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  import tmr_pkg::*;
  logic              clk = 1'b0;      // System clock
  logic              rst;             // Synchronous reset
  logic [ADDR_W-1:0] addr;            // Bus byte address
  logic              rd;              // Bus read strobe
  logic              wr;              // Bus write strobe
  logic [31:0]       wdata;           // Bus write data
  logic [3:0]        be;              // Bus byte enables
  logic [31:0]       rdata;           // Bus read data
  logic              waitreq;         // Bus wait request
  logic              sleep;           // Processor sleep
  logic [1:0]        pdir;            // Port direction bits
  logic [1:0]        pdir_seen;       // Effective pin direction
  logic              osc_pwr;         // Oscillator powered
  logic              trig;            // Compare trigger
  logic              irq;             // Interrupt level
  logic              ext_pin;         // External count pin
  logic              osc_pin;         // Oscillator input pin
  logic [7:0]        q;               // Last byte read
  logic [7:0]        r;               // Random byte
  logic [7:0]        rw [4] = '{IDX_CNT_LO, IDX_CNT_HI, IDX_CMP_LO, IDX_CMP_HI};
  int                errors = 0;      // Mismatch counter
  int                compares = 0;    // Comparison counter

  // 100 MHz clock
  always #5 clk = ~clk;

  timer_counter uut (.sys_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .ext_count_input_in(ext_pin),
    .osc_in_pin_in(osc_pin), .sleep_in(sleep), .port_direction_in(pdir),
    .pin_dir_out(pdir_seen), .osc_power_out(osc_pwr),
    .special_event_out(trig), .irq_out(irq));
  ext_clk_src src_ext (.sys_clk_in(clk), .pin_out(ext_pin));
  ext_clk_src src_osc (.sys_clk_in(clk), .pin_out(osc_pin));

  // Print counts and verdict, then stop
  task automatic tally_and_finish();
    $display("Comparisons %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] bev);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, d};
    be <= bev;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      errors++;
      tally_and_finish();
    end
  endtask

  // Full byte write
  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask

  // Read a register and compare with the expected byte
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                        input string nm);
    bus(1'b0, idx, 8'h00, 4'hF);
    `CHK(nm, exp, q)
  endtask

  // Let the count path settle, then read both bytes
  task automatic cnt_chk(input logic [15:0] exp);
    repeat (16) @(posedge clk);
    rd_chk(IDX_CNT_LO, exp[7:0], "count low");
    rd_chk(IDX_CNT_HI, exp[15:8], "count high");
  endtask

  // Stop the timer, preset the count, then start it with ctl
  task automatic start(input logic [7:0] ctl, input logic [15:0] c);
    wr8(IDX_CTRL, 8'h00);
    wr8(IDX_CNT_LO, c[7:0]);
    wr8(IDX_CNT_HI, c[15:8]);
    wr8(IDX_CTRL, ctl);
  endtask

  // Main sequence
  initial begin
    void'($urandom(9));
    // Idle bus and pins while reset is held
    rst <= 1'b1;
    addr <= '0;
    rd <= 1'b0;
    wr <= 1'b0;
    wdata <= '0;
    be <= 4'hF;
    sleep <= 1'b0;
    pdir <= 2'($urandom);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values and refused accesses
    rd_chk(IDX_CTRL, CTRL_RST, "control");
    rd_chk(IDX_FLAGS, 8'h00, "flags");
    rd_chk(IDX_ENABLES, 8'h00, "enables");
    rd_chk(IDX_CCON, CCON_RST, "cmp control");
    wr8(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00, "unmapped");
    bus(1'b1, IDX_CTRL, 8'h3F, 4'h0);
    rd_chk(IDX_CTRL, 8'h00, "no byte enable");
    // Random bytes through the count, compare and compare control registers
    foreach (rw[i]) begin
      r = 8'($urandom);
      wr8(rw[i], r);
      rd_chk(rw[i], r, "rw byte");
    end
    r = 8'($urandom);
    wr8(IDX_CCON, r);
    rd_chk(IDX_CCON, r & CCON_MASK, "cmp control rw");
    wr8(IDX_CCON, 8'h00);
    // Run bit clear holds the count
    start(8'h30, 16'h1234);
    cnt_chk(16'h1234);
    // Timer mode: one step per instruction cycle times prescale
    for (int ps = 0; ps < 4; ps++) begin
      start(8'h01 | 8'(ps << 4), 16'h0000);
      repeat (40 << ps) @(posedge clk);
      wr8(IDX_CTRL, 8'h00);
      bus(1'b0, IDX_CNT_LO, 8'h00, 4'hF);
      `CHK("timer steps", 1'b1, q >= 8'd9 && q <= 8'd12)
    end
    // Unsynchronised counting in sleep, every prescale code
    sleep <= 1'b1;
    for (int ps = 0; ps < 4; ps++) begin
      start(8'h07 | 8'(ps << 4), 16'h0000);
      src_ext.burst(16);
      cnt_chk(16'(16 >> ps));
    end
    // Overflow in sleep sets the flag and raises the interrupt
    wr8(IDX_ENABLES, 8'h01);
    start(8'h07, 16'hFFFE);
    src_ext.burst(3);
    cnt_chk(16'h0001);
    rd_chk(IDX_FLAGS, 8'h01, "overflow flag");
    `CHK("irq", 1'b1, irq)
    wr8(IDX_ENABLES, 8'h00);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr8(IDX_FLAGS, 8'h01);
    rd_chk(IDX_FLAGS, 8'h00, "flag cleared");
    // Synchronised counting stands still in sleep
    start(8'h03, 16'h0000);
    src_ext.burst(8);
    cnt_chk(16'h0000);
    sleep <= 1'b0;
    start(8'h03, 16'h0000);
    src_ext.burst(6);
    cnt_chk(16'h0006);
    // Oscillator pin counts, the other pin is ignored
    start(8'h0F, 16'h0000);
    fork
      src_osc.burst(5);
      src_ext.burst(9);
    join
    cnt_chk(16'h0005);
    `CHK("pins input", PIN_ALL_INPUT, pdir_seen)
    `CHK("osc power", 1'b1, osc_pwr)
    wr8(IDX_CTRL, 8'h00);
    @(negedge clk);
    `CHK("pins free", pdir, pdir_seen)
    `CHK("osc off", 1'b0, osc_pwr)
    // Special event trigger clears the count on the next step
    wr8(IDX_CMP_LO, 8'h03);
    wr8(IDX_CMP_HI, 8'h00);
    wr8(IDX_CCON, {4'h0, CMODE_SPECIAL});
    start(8'h03, 16'h0000);
    src_ext.burst(3);
    cnt_chk(16'h0003);
    `CHK("trigger", 1'b1, trig)
    src_ext.burst(1);
    cnt_chk(16'h0000);
    rd_chk(IDX_CTRL, 8'h03, "control kept");
    // Match removed before the step: no clear
    src_ext.burst(3);
    cnt_chk(16'h0003);
    wr8(IDX_CMP_LO, 8'h07);
    src_ext.burst(1);
    cnt_chk(16'h0004);
    // Unsynchronised mode never triggers
    start(8'h07, 16'h0007);
    @(negedge clk);
    `CHK("no async trigger", 1'b0, trig)
    // Reset in mid-run returns registers to their reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(IDX_CTRL, CTRL_RST, "control after reset");
    rd_chk(IDX_CNT_LO, 8'h00, "count after reset");
    `CHK("trigger after reset", 1'b0, trig)
    tally_and_finish();
  end
endmodule

// >>> rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
  input  wire logic sys_clk_in,  // System clock
  input  wire logic rst_in,      // Synchronous reset, active high
  input  wire logic pin_in,      // Asynchronous pin level
  output logic      level_out    // Filtered level
);

  // Synchroniser stages and accepted level
  typedef struct packed {
    logic s1;   // First stage, read only by s2
    logic s2;   // Second stage
    logic s3;   // Third stage
    logic lvl;  // Accepted level
  } sync_t;

  sync_t q;  // Registered state
  sync_t d;  // Next state

  // Shift the pin in; accept a level once stages two and three agree
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.lvl;

endmodule

// >>> rtl/timer_counter.sv
// Sixteen-bit timer/counter with compare reset on an Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// How it works
// - 16-bit count in two bytes, wraps
// - Wrap sets overflow flag; enable gates interrupt
// - Timer mode counts once per instruction cycle
// - Counter mode counts rising edges of chosen pin
// - Run bit clear holds the count
// - Prescale field divides by 1, 2, 4, 8
// - Sync-disable bit selects unsynchronised counting, counter mode only
// - Synchroniser sits after the prescaler
// - Synchronised mode freezes count in sleep
// - Prescaler output sampled on phases two, four
// - Unsynchronised mode counts and interrupts in sleep
// - Count byte reads return a stable value
// - Unsynchronised mode gives no compare trigger
// - Oscillator enable forces both pins to input
// - Special mode match triggers, clears on tick
// - Vanished match cancels the pending clear
module timer_counter (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_in,
  input  wire logic [tmr_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  input  wire logic                      ext_count_input_in,
  input  wire logic                      osc_in_pin_in,
  input  wire logic                      sleep_in,
  input  wire logic [1:0]                port_direction_in,
  output logic      [1:0]                pin_dir_out,
  output logic                           osc_power_out,
  output logic                           special_event_out,
  output logic                           irq_out
);
  import tmr_pkg::*;

  // Whole state of the block
  typedef struct packed {
    bus_state_t         bus;        // Bus handshake state
    logic [7:0]         rdata;      // Read data held for the master
    logic [7:0]         ctrl;       // timer_control
    logic [7:0]         ccon;       // compare_unit_control
    logic [15:0]        count;      // count_high_byte:count_low_byte
    logic [15:0]        cmp;        // compare_high_byte:compare_low_byte
    logic               ovf_flag;   // overflow_flag
    logic               ovf_en;     // overflow_irq_enable
    logic [1:0]         phase;      // Instruction cycle phase
    logic [PRESC_W-1:0] presc;      // Prescaler counter
    logic               in_prev;    // Last filtered input level
    logic               presc_lvl;  // Prescaler output level
    logic               samp;       // Sampled prescaler output
  } state_t;

  // Reset image of the state
  localparam state_t STATE_RST = '{
    bus:       BUS_IDLE,
    rdata:     8'h00,
    ctrl:      CTRL_RST,
    ccon:      CCON_RST,
    count:     CNT_RST,
    cmp:       CMP_RST,
    ovf_flag:  1'b0,
    ovf_en:    1'b0,
    phase:     2'h0,
    presc:     '0,
    in_prev:   1'b0,
    presc_lvl: 1'b0,
    samp:      1'b0
  };

  state_t             q;           // Registered state
  state_t             d;           // Next state
  logic               src_pin;     // Selected external pin
  logic               ext_lvl;     // Filtered external level
  logic               req;         // Bus request present
  logic               acking;      // Bus access completes this cycle
  logic               wr_en;       // Register write takes effect
  logic [7:0]         reg_idx;     // Register index from address
  logic [7:0]         wdat;        // Write data byte
  logic               run;         // run_enable
  logic               cs;          // clock_source_select
  logic               syncn;       // sync_disable_n
  logic               oscen;       // oscillator_enable
  logic [1:0]         ps;          // prescale_field
  logic [PRESC_W-1:0] ps_mask;     // Prescaler terminal mask
  logic               inst_tick;   // End of an instruction cycle
  logic               ext_rise;    // Rising edge on external input
  logic               src_tick;    // Prescaler input event
  logic               pre_tick;    // Prescaler output event
  logic               sync_mode;   // Synchronised counter mode
  logic               sample_now;  // Synchroniser sampling phase
  logic               sync_tick;   // Synchronised count event
  logic               cnt_tick;    // Count advances this cycle
  logic               base_ok;     // Count usable as compare base
  logic               match;       // Special event compare match
  logic               wrap;        // Count wraps this cycle

  // Control field decode
  assign run   = q.ctrl[RUN_BIT];
  assign cs    = q.ctrl[CS_BIT];
  assign syncn = q.ctrl[SYNCN_BIT];
  assign oscen = q.ctrl[OSCEN_BIT];
  assign ps    = q.ctrl[PS_MSB:PS_LSB];

  // Oscillator pin when enabled, else the clock input pin
  assign src_pin = oscen ? osc_in_pin_in : ext_count_input_in;

  // Pin synchroniser for the selected source
  pin_sync u_src_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pin_in     (src_pin),
    .level_out  (ext_lvl)
  );

  // Bus request decode
  assign req     = avs_read_in | avs_write_in;
  assign acking  = (q.bus == BUS_ACK);
  assign wr_en   = acking & avs_write_in & avs_byteenable_in[0];
  assign reg_idx = avs_address_in[ADDR_W-1:2];
  assign wdat    = avs_writedata_in[7:0];

  // Instruction clock stops in sleep
  assign inst_tick = (q.phase == PHASE_FOUR) & ~sleep_in;
  assign ext_rise  = ext_lvl & ~q.in_prev;

  // Prescaler input: instruction cycle or external edge, while running
  assign src_tick = (cs ? ext_rise : inst_tick) & run;

  // Divide by 2^field: all low bits set marks the terminal count
  assign ps_mask  = PRESC_W'((4'h1 << ps) - 4'h1);
  assign pre_tick = src_tick & ((q.presc & ps_mask) == ps_mask);

  // Synchronised path samples prescaler output, not the raw pin
  assign sync_mode  = cs & ~syncn;
  assign sample_now = ((q.phase == PHASE_TWO) |
                       (q.phase == PHASE_FOUR)) & ~sleep_in;
  assign sync_tick  = sample_now & (q.samp != q.presc_lvl);

  // Synchronised counting stops in sleep; otherwise the prescaler rules
  assign cnt_tick = run & (sync_mode ? sync_tick : pre_tick);

  // Unsynchronised counting is no compare base
  assign base_ok = ~(cs & syncn);
  assign match   = base_ok &
                   (q.ccon[CMODE_MSB:CMODE_LSB] == CMODE_SPECIAL) &
                   (q.count == q.cmp);
  assign wrap    = cnt_tick & ~match & (q.count == CNT_MAX);

  // Next-state logic
  always_comb begin
    logic [7:0] rd_val;
    rd_val = 8'h00;
    d = q;
    d.phase   = q.phase + 2'h1;
    d.in_prev = ext_lvl;

    // Read mux; unmapped indices read zero
    if (reg_idx == IDX_FLAGS) begin
      rd_val[OVF_BIT] = q.ovf_flag;
    end else if (reg_idx == IDX_CNT_LO) begin
      rd_val = q.count[7:0];
    end else if (reg_idx == IDX_CNT_HI) begin
      rd_val = q.count[15:8];
    end else if (reg_idx == IDX_CTRL) begin
      rd_val = q.ctrl;
    end else if (reg_idx == IDX_CMP_LO) begin
      rd_val = q.cmp[7:0];
    end else if (reg_idx == IDX_CMP_HI) begin
      rd_val = q.cmp[15:8];
    end else if (reg_idx == IDX_CCON) begin
      rd_val = q.ccon;
    end else if (reg_idx == IDX_ENABLES) begin
      rd_val[OVF_BIT] = q.ovf_en;
    end

    // One wait cycle per access; read data captured from one edge
    case (q.bus)
      BUS_IDLE: begin
        if (req) begin
          d.bus   = BUS_ACK;
          d.rdata = avs_read_in ? rd_val : 8'h00;
        end
      end
      BUS_ACK: begin
        d.bus = BUS_IDLE;
      end
      default: begin
        d.bus = BUS_IDLE;
      end
    endcase

    // Prescaler keeps counting external edges in sleep; instruction ticks stop
    if (src_tick) begin
      d.presc = q.presc + PRESC_W'(1);
    end
    // Prescaler output toggles once per divided event
    if (pre_tick) begin
      d.presc_lvl = ~q.presc_lvl;
    end
    // Synchroniser samples on phases two and four
    if (sample_now) begin
      d.samp = q.presc_lvl;
    end

    // Count advance; a match still present at the tick clears it
    if (cnt_tick) begin
      if (match) begin
        d.count = CNT_RST;
      end else begin
        d.count = q.count + 16'h0001;
      end
    end

    // Overflow flag: write one clears, a wrap in that cycle wins
    if (wr_en && reg_idx == IDX_FLAGS && wdat[OVF_BIT]) begin
      d.ovf_flag = 1'b0;
    end
    if (wrap) begin
      d.ovf_flag = 1'b1;
    end

    // Register writes; a byte write wins over a coincident increment
    if (wr_en) begin
      if (reg_idx == IDX_CNT_LO) begin
        d.count[7:0] = wdat;
      end else if (reg_idx == IDX_CNT_HI) begin
        d.count[15:8] = wdat;
      end else if (reg_idx == IDX_CTRL) begin
        d.ctrl = wdat & CTRL_MASK;
      end else if (reg_idx == IDX_CMP_LO) begin
        d.cmp[7:0] = wdat;
      end else if (reg_idx == IDX_CMP_HI) begin
        d.cmp[15:8] = wdat;
      end else if (reg_idx == IDX_CCON) begin
        d.ccon = wdat & CCON_MASK;
      end else if (reg_idx == IDX_ENABLES) begin
        d.ovf_en = wdat[OVF_BIT];
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Bus answers
  assign avs_waitrequest_out = req & ~acking;
  assign avs_readdata_out    = {24'h000000, q.rdata};

  // Interrupt level, also the wake request in sleep
  assign irq_out = q.ovf_flag & q.ovf_en;

  // Trigger rises at once on a match
  assign special_event_out = match;

  // Oscillator enable forces both pins to input and powers the oscillator
  assign pin_dir_out   = oscen ? PIN_ALL_INPUT : port_direction_in;
  assign osc_power_out = oscen;

  // Wrap returns the count to zero
  count_wrap_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wrap && !wr_en |=> q.count == CNT_RST)
    else $error("count did not wrap to zero");

  // Wrap raises the flag and, when enabled, the interrupt
  ovf_irq_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wrap && q.ovf_en && !wr_en |=> q.ovf_flag && irq_out)
    else $error("overflow did not raise flag and interrupt");

  // Timer mode, divide by one: one step per instruction cycle
  timer_step_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !cs && run && ps == 2'h0 && q.phase == PHASE_FOUR && !sleep_in
      && !match && !wr_en
    |=> q.count == $past(q.count) + 16'h0001)
    else $error("timer mode missed its instruction-cycle step");

  // Stopped timer holds its count
  stop_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !run && !acking |=> $stable(q.count))
    else $error("count moved while stopped");

  // Divide by eight steps only at the terminal prescaler count
  prescale_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    pre_tick && ps == 2'h3 |-> q.presc == 3'h7)
    else $error("prescaler terminal count wrong");

  // Two cycles of synchronised mode in sleep: the count holds at the next edge
  sleep_freeze_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (sync_mode && sleep_in && !acking)[*2] |=> $stable(q.count))
    else $error("count moved in synchronised sleep");

  // Unsynchronised counting never triggers a compare event
  no_async_cmp_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    cs && syncn |-> !special_event_out)
    else $error("trigger raised on unsynchronised base");

  // Match at a tick clears both bytes and keeps control
  event_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    cnt_tick && match && !wr_en
    |=> q.count == CNT_RST && $stable(q.ctrl))
    else $error("special event did not clear the count");

  // Oscillator enabled: both pins read as inputs
  pins_input_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    oscen |-> pin_dir_out == PIN_ALL_INPUT)
    else $error("oscillator pins not forced to input");

  // Every request is answered within two cycles
  bus_answer_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    req && !acking |=> !avs_waitrequest_out)
    else $error("bus access not answered in time");

  // A step without a match only increments; no clear is left pending
  step_no_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    cnt_tick && !match && !wr_en
    |=> q.count == $past(q.count) + 16'h0001)
    else $error("count cleared or skipped without a match");

  // A wrap sets the flag even when software clears it in that cycle
  flag_set_wins_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wrap |=> q.ovf_flag)
    else $error("wrap did not set the overflow flag");

endmodule

// >>> rtl/tmr_pkg.sv
// Constants and types shared by the timer/counter design
package tmr_pkg;

  // Avalon byte address width; register index sits in bits [9:2]
  localparam int ADDR_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_CNT_LO  = 8'h0E;
  localparam logic [7:0] IDX_CNT_HI  = 8'h0F;
  localparam logic [7:0] IDX_CTRL    = 8'h10;
  localparam logic [7:0] IDX_CMP_LO  = 8'h15;
  localparam logic [7:0] IDX_CMP_HI  = 8'h16;
  localparam logic [7:0] IDX_CCON    = 8'h17;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;

  // Field positions in timer_control
  localparam int RUN_BIT   = 0;
  localparam int CS_BIT    = 1;
  localparam int SYNCN_BIT = 2;
  localparam int OSCEN_BIT = 3;
  localparam int PS_LSB    = 4;
  localparam int PS_MSB    = 5;

  // Overflow bit in peripheral_flags and peripheral_enables
  localparam int OVF_BIT = 0;

  // Compare mode field in compare_unit_control
  localparam int         CMODE_LSB    = 0;
  localparam int         CMODE_MSB    = 3;
  localparam logic [3:0] CMODE_SPECIAL = 4'hB;

  // Reset values and writable masks
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  CTRL_MASK = 8'h3F;
  localparam logic [7:0]  CCON_RST  = 8'h00;
  localparam logic [7:0]  CCON_MASK = 8'h3F;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CMP_RST   = 16'h0000;

  // Both oscillator pins forced to input
  localparam logic [1:0] PIN_ALL_INPUT = 2'h3;

  // Instruction cycle: four phases of the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int INST_CYCLE_NS = 40;
  localparam int INST_CYCLE_CLKS = INST_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PHASE_TWO  = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;

  // Prescaler ripple counter width (divide by up to 8)
  localparam int PRESC_W = 3;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage
